// >>> design/sdpi_core.sv
`include "sdpi_params.svh"
module sdpi_core (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rstn,
  // Command pins
  input  wire logic                     cke,
  input  wire sdpi_pkg::sdpi_pins_t     cmd_pins,
  input  wire logic                     low_byte_mask,
  input  wire logic                     high_byte_mask,
  // Data lines
  input  wire logic [`SDPI_DATA_W-1:0]  data_lines_in,
  output logic [`SDPI_DATA_W-1:0]       data_lines_out,
  output logic [`SDPI_DATA_W-1:0]       data_lines_oe,
  // Status
  output sdpi_pkg::sdpi_lp_t            power_state,
  output logic [`SDPI_BANKS-1:0]        bank_open,
  output logic                          cmd_error,
  output logic                          write_queue_full
);
  sdpi_pkg::sdpi_state_t   state_reg;
  sdpi_pkg::sdpi_state_t   state_next;
  sdpi_pkg::sdpi_cmd_t     cmd;
  sdpi_pkg::sdpi_idx_t     cmd_idx;
  sdpi_pkg::sdpi_wr_t      wq_in;
  sdpi_pkg::sdpi_wr_t      wq_out;
  sdpi_pkg::sdpi_rd_t      rd_out;
  logic [1:0]              dqm_out;
  logic [`SDPI_BANK_W-1:0] bank;
  logic                    edge_ok;
  logic                    sel;
  logic                    scope;
  logic                    rd_go;
  logic                    wr_cmd;
  logic                    wr_go;
  logic                    wq_in_ready;
  logic                    wq_out_valid;
  logic                    wq_pop;
  logic                    busy;
  logic [7:0]              hi_now;
  logic [7:0]              lo_now;
  logic [`SDPI_DATA_W-1:0] mem [0:(1<<$bits(sdpi_pkg::sdpi_idx_t))-1];

  // Clock gate used as a live level, so a low level stops the very next edge
  assign edge_ok = cke;
  assign sel     = !cmd_pins.cs_n;
  assign cmd     = sdpi_pkg::sdpi_cmd_t'({cmd_pins.ras_n, cmd_pins.cas_n, cmd_pins.we_n});
  assign bank    = cmd_pins.bank_select;
  assign scope   = cmd_pins.addr[`SDPI_SCOPE_BIT];
  assign cmd_idx = {bank, state_reg.open_row[bank][`SDPI_ROW_BITS-1:0], cmd_pins.addr[`SDPI_COL_BITS-1:0]};
  assign rd_go   = edge_ok && sel && cmd == sdpi_pkg::cmd_read && state_reg.bank_open[bank];
  assign wr_cmd  = edge_ok && sel && cmd == sdpi_pkg::cmd_write && state_reg.bank_open[bank];
  assign wr_go   = wr_cmd && wq_in_ready;

  // Write data and masks travel together into the queue
  assign wq_in.idx  = cmd_idx;
  assign wq_in.data = data_lines_in;
  assign wq_in.mask = {high_byte_mask, low_byte_mask};

  // Array drains only on valid edges; self refresh holds the queue
  assign wq_pop = wq_out_valid && edge_ok && state_reg.lp != sdpi_pkg::lp_self_refresh;
  assign busy   = wq_out_valid || state_reg.rd_pipe[0].valid || state_reg.rd_pipe[1].valid ||
                  state_reg.rd_pipe[2].valid;
  assign rd_out  = (state_reg.cl == `SDPI_CL_3) ? state_reg.rd_pipe[2] : state_reg.rd_pipe[1];
  assign dqm_out = state_reg.dqm_pipe[`SDPI_DQM_STAGES-1];
  assign hi_now  = mem[wq_out.idx][15:8];
  assign lo_now  = mem[wq_out.idx][7:0];

  sdpi_fifo #(
    .WIDTH ($bits(sdpi_pkg::sdpi_wr_t)),
    .DEPTH (`SDPI_WQ_DEPTH)
  ) u_wq (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (wr_go),
    .in_ready  (wq_in_ready),
    .in_data   (wq_in),
    .out_valid (wq_out_valid),
    .out_ready (wq_pop),
    .out_data  (wq_out)
  );

  // Masked bytes never reach the array
  always_ff @(posedge clk) begin
    if (wq_pop) begin
      for (int b = 0; b < 2; b++) begin
        if (!wq_out.mask[b]) begin
          mem[wq_out.idx][b*8 +: 8] <= wq_out.data[b*8 +: 8];
        end
      end
    end
  end

  always_comb begin
    state_next         = state_reg;
    state_next.wq_full = !wq_in_ready;
    // Low-power state is judged on every edge, gated or not
    if (!cke) begin
      if (state_reg.lp == sdpi_pkg::lp_none) begin
        if (sel && cmd == sdpi_pkg::cmd_ref) begin
          state_next.lp = sdpi_pkg::lp_self_refresh;
        end else if (busy) begin
          state_next.lp = sdpi_pkg::lp_suspend;
        end else begin
          state_next.lp = sdpi_pkg::lp_power_down;
        end
      end
    end else begin
      state_next.lp = sdpi_pkg::lp_none;
    end
    if (edge_ok) begin
      state_next.rd_pipe[0]  = '{valid: rd_go, idx: cmd_idx};
      state_next.rd_pipe[1]  = state_reg.rd_pipe[0];
      state_next.rd_pipe[2]  = state_reg.rd_pipe[1];
      state_next.dqm_pipe[0] = {high_byte_mask, low_byte_mask};
      state_next.dqm_pipe[1] = state_reg.dqm_pipe[0];
      // Each byte enabled from its own mask, two edges old
      state_next.oe = {{8{rd_out.valid && !dqm_out[1]}}, {8{rd_out.valid && !dqm_out[0]}}};
      state_next.dout      = rd_out.valid ? mem[rd_out.idx] : '0;
      state_next.cmd_error = 1'b0;
      // Deselected cycles fall through: pipelines keep running, nothing new starts
      if (sel) begin
        unique case (cmd)
          sdpi_pkg::cmd_act: begin
            if (state_reg.bank_open[bank]) begin
              state_next.cmd_error = 1'b1;
            end else begin
              state_next.bank_open[bank] = 1'b1;
              state_next.open_row[bank]  = cmd_pins.addr;
            end
          end
          sdpi_pkg::cmd_read, sdpi_pkg::cmd_write: begin
            if (!state_reg.bank_open[bank] || (wr_cmd && !wq_in_ready)) begin
              state_next.cmd_error = 1'b1;
            end else if (scope) begin
              // Single-beat access, so auto precharge closes at once
              state_next.bank_open[bank] = 1'b0;
            end
          end
          sdpi_pkg::cmd_pre: begin
            if (scope) begin
              state_next.bank_open = '0;
            end else begin
              state_next.bank_open[bank] = 1'b0;
            end
          end
          sdpi_pkg::cmd_lmr: begin
            if (|state_reg.bank_open) begin
              state_next.cmd_error = 1'b1;
            end else if (cmd_pins.addr[`SDPI_CL_LSB +: `SDPI_CL_W] == `SDPI_CL_2 ||
                         cmd_pins.addr[`SDPI_CL_LSB +: `SDPI_CL_W] == `SDPI_CL_3) begin
              state_next.cl = cmd_pins.addr[`SDPI_CL_LSB +: `SDPI_CL_W];
            end else begin
              state_next.cmd_error = 1'b1;
            end
          end
          sdpi_pkg::cmd_ref: begin
            state_next.cmd_error = |state_reg.bank_open;
          end
          sdpi_pkg::cmd_nop, sdpi_pkg::cmd_bst: begin
            state_next.cmd_error = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg    <= '0;
      state_reg.cl <= `SDPI_CL_RST;
      state_reg.lp <= sdpi_pkg::lp_none;
    end else begin
      state_reg <= state_next;
    end
  end

  assign data_lines_out   = state_reg.dout;
  assign data_lines_oe    = state_reg.oe;
  assign power_state      = state_reg.lp;
  assign bank_open        = state_reg.bank_open;
  assign cmd_error        = state_reg.cmd_error;
  assign write_queue_full = state_reg.wq_full;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_live2;
    cke ##1 cke;
  endsequence

  sequence s_quiet2;
    (cke && cmd_pins.cs_n) ##1 (cke && cmd_pins.cs_n);
  endsequence

  property p_hi_mask_off;
    (cke && high_byte_mask) ##1 s_live2 |=> !data_lines_oe[15] && !data_lines_oe[8];
  endproperty
  a_hi_mask_off: assert property (p_hi_mask_off) else $error("upper byte driven despite mask");

  property p_lo_mask_off;
    (cke && low_byte_mask) ##1 s_live2 |=> !data_lines_oe[7] && !data_lines_oe[0];
  endproperty
  a_lo_mask_off: assert property (p_lo_mask_off) else $error("lower byte driven despite mask");

  property p_read_drive;
    (rd_go && state_reg.cl == `SDPI_CL_2 && !low_byte_mask) ##1 s_quiet2 |=> data_lines_oe[0] && data_lines_oe[7];
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("unmasked read byte not driven");

  property p_freeze;
    !cke |=> $stable(bank_open) && $stable(data_lines_oe) && $stable(data_lines_out);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved on a gated edge");

  property p_lp_enter;
    !cke |=> power_state != sdpi_pkg::lp_none;
  endproperty
  a_lp_enter: assert property (p_lp_enter) else $error("clock gate low without low-power state");

  property p_deselect_hold;
    (cke && cmd_pins.cs_n) |=> bank_open == $past(bank_open) && !cmd_error;
  endproperty
  a_deselect_hold: assert property (p_deselect_hold) else $error("deselected cycle changed banks");

  property p_activate;
    (cke && sel && cmd == sdpi_pkg::cmd_act) |=> bank_open[$past(bank)];
  endproperty
  a_activate: assert property (p_activate) else $error("activated bank not open");

  property p_pre_all;
    (cke && sel && cmd == sdpi_pkg::cmd_pre && scope) |=> bank_open == '0;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");

  property p_mask_write;
    (wq_pop && wq_out.mask[1]) |=> mem[$past(wq_out.idx)][15:8] == $past(hi_now);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("masked upper byte was written");

  property p_mode_load;
    (cke && sel && cmd == sdpi_pkg::cmd_lmr && bank_open == '0 &&
     cmd_pins.addr[`SDPI_CL_LSB +: `SDPI_CL_W] == `SDPI_CL_3) |=> state_reg.cl == `SDPI_CL_3;
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("mode load ignored");

  // Byte groups never split: the pins switch a whole byte at a time
  property p_oe_group;
    data_lines_oe[15:8] inside {8'h00, 8'hFF} && data_lines_oe[7:0] inside {8'h00, 8'hFF};
  endproperty
  a_oe_group: assert property (p_oe_group) else $error("byte enable group split");

  // Checked on an empty queue only, so the head is the entry just pushed
  property p_write_pair;
    (wr_go && !wq_out_valid) |=> wq_out.mask == $past({high_byte_mask, low_byte_mask}) &&
                                 wq_out.data == $past(data_lines_in);
  endproperty
  a_write_pair: assert property (p_write_pair) else $error("write data and mask not taken together");

  property p_lo_mask_write;
    (wq_pop && wq_out.mask[0]) |=> mem[$past(wq_out.idx)][7:0] == $past(lo_now);
  endproperty
  a_lo_mask_write: assert property (p_lo_mask_write) else $error("masked lower byte was written");

  property p_lo_write;
    (wq_pop && !wq_out.mask[0]) |=> mem[$past(wq_out.idx)][7:0] == $past(wq_out.data[7:0]);
  endproperty
  a_lo_write: assert property (p_lo_write) else $error("unmasked lower byte not stored");

  property p_deselect_start;
    (cke && cmd_pins.cs_n) |=> !state_reg.rd_pipe[0].valid;
  endproperty
  a_deselect_start: assert property (p_deselect_start) else $error("read started while deselected");

  // Same-edge level of the gate counts, not a copy taken one edge earlier
  property p_live_gate;
    (!cke && sel && cmd == sdpi_pkg::cmd_act && !state_reg.bank_open[bank]) |=> !bank_open[$past(bank)];
  endproperty
  a_live_gate: assert property (p_live_gate) else $error("gated edge took a command");

  property p_lp_exit;
    cke |=> power_state == sdpi_pkg::lp_none;
  endproperty
  a_lp_exit: assert property (p_lp_exit) else $error("low-power state kept with clock gate high");

  property p_mask_capture;
    cke |=> state_reg.dqm_pipe[0] == $past({high_byte_mask, low_byte_mask});
  endproperty
  a_mask_capture: assert property (p_mask_capture) else $error("mask not captured on the clock edge");

  property p_pre_one;
    (cke && sel && cmd == sdpi_pkg::cmd_pre && !scope) |=> !bank_open[$past(bank)];
  endproperty
  a_pre_one: assert property (p_pre_one) else $error("precharge left its bank open");

  property p_refresh_busy;
    (cke && sel && cmd == sdpi_pkg::cmd_ref && bank_open != '0) |=> cmd_error;
  endproperty
  a_refresh_busy: assert property (p_refresh_busy) else $error("refresh with an open bank not flagged");

  // Single-beat access: auto precharge closes the bank at the command edge
  property p_auto_close;
    (rd_go && scope) |=> !bank_open[$past(bank)];
  endproperty
  a_auto_close: assert property (p_auto_close) else $error("auto precharge left the bank open");
endmodule : sdpi_core

// >>> design/sdpi_params.svh
`ifndef SDPI_PARAMS_SVH
`define SDPI_PARAMS_SVH

// Strobe patterns {row, column, write}, all active low
`define SDPI_CMD_LMR   3'h0
`define SDPI_CMD_REF   3'h1
`define SDPI_CMD_PRE   3'h2
`define SDPI_CMD_ACT   3'h3
`define SDPI_CMD_WRITE 3'h4
`define SDPI_CMD_READ  3'h5
`define SDPI_CMD_BST   3'h6
`define SDPI_CMD_NOP   3'h7

`define SDPI_ADDR_W    12
`define SDPI_BANK_W    2
`define SDPI_BANKS     4
`define SDPI_DATA_W    16
`define SDPI_SCOPE_BIT 10
`define SDPI_CL_LSB    4
`define SDPI_CL_W      3
`define SDPI_CL_2      3'h2
`define SDPI_CL_3      3'h3
`define SDPI_CL_RST    3'h2
`define SDPI_RD_STAGES 3
`define SDPI_DQM_STAGES 2
`define SDPI_ROW_BITS  2
`define SDPI_COL_BITS  4
`define SDPI_WQ_DEPTH  32
`endif

// >>> design/sdpi_pkg.sv
`include "sdpi_params.svh"
package sdpi_pkg;
  typedef enum logic [2:0] {
    cmd_lmr   = `SDPI_CMD_LMR,
    cmd_ref   = `SDPI_CMD_REF,
    cmd_pre   = `SDPI_CMD_PRE,
    cmd_act   = `SDPI_CMD_ACT,
    cmd_write = `SDPI_CMD_WRITE,
    cmd_read  = `SDPI_CMD_READ,
    cmd_bst   = `SDPI_CMD_BST,
    cmd_nop   = `SDPI_CMD_NOP
  } sdpi_cmd_t;

  typedef enum logic [1:0] {lp_none, lp_power_down, lp_suspend, lp_self_refresh} sdpi_lp_t;

  typedef logic [`SDPI_BANK_W+`SDPI_ROW_BITS+`SDPI_COL_BITS-1:0] sdpi_idx_t;

  typedef struct packed {
    logic                      cs_n;
    logic                      ras_n;
    logic                      cas_n;
    logic                      we_n;
    logic [`SDPI_BANK_W-1:0]   bank_select;
    logic [`SDPI_ADDR_W-1:0]   addr;
  } sdpi_pins_t;

  typedef struct packed {
    sdpi_idx_t                 idx;
    logic [`SDPI_DATA_W-1:0]   data;
    logic [1:0]                mask;
  } sdpi_wr_t;

  typedef struct packed {
    logic                      valid;
    sdpi_idx_t                 idx;
  } sdpi_rd_t;

  typedef struct packed {
    logic [`SDPI_BANKS-1:0]                       bank_open;
    logic [`SDPI_BANKS-1:0][`SDPI_ADDR_W-1:0]     open_row;
    logic [`SDPI_CL_W-1:0]                        cl;
    sdpi_rd_t [`SDPI_RD_STAGES-1:0]               rd_pipe;
    logic [`SDPI_DQM_STAGES-1:0][1:0]             dqm_pipe;
    sdpi_lp_t                                     lp;
    logic [`SDPI_DATA_W-1:0]                      dout;
    logic [`SDPI_DATA_W-1:0]                      oe;
    logic                                         cmd_error;
    logic                                         wq_full;
  } sdpi_state_t;
endpackage : sdpi_pkg

// >>> design/sdpi_fifo.sv
`include "sdpi_params.svh"
module sdpi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SDPI_WQ_DEPTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW:0] wr_ptr;
    logic [PW:0] rd_ptr;
  } sdpi_fifo_state_t;

  sdpi_fifo_state_t state_reg;
  sdpi_fifo_state_t state_next;
  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty
  assign full      = (state_reg.wr_ptr[PW] != state_reg.rd_ptr[PW]) &&
                     (state_reg.wr_ptr[PW-1:0] == state_reg.rd_ptr[PW-1:0]);
  assign empty     = state_reg.wr_ptr == state_reg.rd_ptr;
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;
  assign out_data  = store[state_reg.rd_ptr[PW-1:0]];

  always_comb begin
    state_next = state_reg;
    if (push) begin
      state_next.wr_ptr = state_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      state_next.rd_ptr = state_reg.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      store[state_reg.wr_ptr[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule : sdpi_fifo

// >>> sim/sdpi_ctrl_model.sv
`include "sdpi_params.svh"
module sdpi_ctrl_model (
  // Clock
  input  wire logic                    clk,
  // Command side toward the device
  output sdpi_pkg::sdpi_pins_t         cmd_pins,
  output logic                         cke,
  output logic                         low_byte_mask,
  output logic                         high_byte_mask,
  // Shared data wire
  input  wire logic [`SDPI_DATA_W-1:0] dev_out,
  input  wire logic [`SDPI_DATA_W-1:0] dev_oe,
  output logic [`SDPI_DATA_W-1:0]      data_wire
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [`SDPI_DATA_W-1:0] wdata;
  logic                    wr_drive;

  initial begin
    cmd_pins       = '{1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 12'h000};
    cke            = 1'b1;
    low_byte_mask  = 1'b0;
    high_byte_mask = 1'b0;
    wdata          = 16'h0000;
    wr_drive       = 1'b0;
  end

  // Released lines show the inverse of the last value, never a stale copy
  assign data_wire = (dev_oe & dev_out) | (~dev_oe & (wr_drive ? wdata : ~wdata));

  task automatic drive(input sdpi_pkg::sdpi_cmd_t c, input logic sel_n, input logic [1:0] bk,
                       input logic [11:0] a, input logic [1:0] m, input logic [15:0] d, input logic ck);
    logic [2:0] s;
    s = c;
    @(posedge clk);
    cmd_pins       <= '{sel_n, s[2], s[1], s[0], bk, a};
    low_byte_mask  <= m[0];
    high_byte_mask <= m[1];
    wr_drive       <= (c == sdpi_pkg::cmd_write);
    if (c == sdpi_pkg::cmd_write) begin
      wdata <= d;
    end
    cke <= ck;
  endtask : drive
endmodule : sdpi_ctrl_model

// >>> sim/sdram_pin_command_interface_tb_top.sv
`include "sdpi_params.svh"
module sdram_pin_command_interface_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 clk;
  logic                 rstn;
  sdpi_pkg::sdpi_pins_t pins;
  logic                 cke;
  logic                 lm;
  logic                 hm;
  logic [15:0]          dwire;
  logic [15:0]          dout;
  logic [15:0]          oe;
  sdpi_pkg::sdpi_lp_t   pstate;
  logic [3:0]           bopen;
  logic                 cerr;
  logic                 wqf;
  int                   errors;
  int                   n_compared;

  sdpi_ctrl_model u_ctrl (.clk(clk), .cmd_pins(pins), .cke(cke), .low_byte_mask(lm), .high_byte_mask(hm),
                          .dev_out(dout), .dev_oe(oe), .data_wire(dwire));
  sdpi_core u_dut (.clk(clk), .rstn(rstn), .cke(cke), .cmd_pins(pins), .low_byte_mask(lm),
                   .high_byte_mask(hm), .data_lines_in(dwire), .data_lines_out(dout), .data_lines_oe(oe),
                   .power_state(pstate), .bank_open(bopen), .cmd_error(cerr), .write_queue_full(wqf));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic op(input sdpi_pkg::sdpi_cmd_t c, input logic [1:0] b, input logic [11:0] a,
                    input logic [1:0] m, input logic [15:0] d);
    u_ctrl.drive(c, 1'b0, b, a, m, d, 1'b1);
  endtask : op

  task automatic idle(input int n);
    repeat (n) op(sdpi_pkg::cmd_nop, 2'h0, 12'h000, 2'h0, 16'h0000);
    #1;
  endtask : idle

  task automatic t_reset;
    chk(oe, 16'h0000);
    chk(bopen, 16'h0000);
    chk(16'(pstate), 16'(sdpi_pkg::lp_none));
    chk(cerr, 16'h0000);
  endtask : t_reset

  task automatic t_activate;
    op(sdpi_pkg::cmd_act, 2'h1, 12'h001, 2'h0, 16'h0000);
    idle(1);
    chk(bopen, 16'h0002);
    op(sdpi_pkg::cmd_act, 2'h1, 12'h001, 2'h0, 16'h0000);
    idle(1);
    chk(cerr, 16'h0001);
  endtask : t_activate

  task automatic t_write_read;
    op(sdpi_pkg::cmd_write, 2'h1, 12'h003, 2'h0, 16'hA5C3);
    op(sdpi_pkg::cmd_write, 2'h1, 12'h003, 2'h1, 16'h1E2D);
    op(sdpi_pkg::cmd_read, 2'h1, 12'h003, 2'h2, 16'h0000);
    idle(3);
    chk(oe, 16'h00FF);
    chk(dout & 16'h00FF, 16'h00C3);
    op(sdpi_pkg::cmd_read, 2'h1, 12'h003, 2'h0, 16'h0000);
    op(sdpi_pkg::cmd_nop, 2'h0, 12'h000, 2'h3, 16'h0000);
    idle(2);
    chk(oe, 16'hFFFF);
    chk(dout, 16'h1EC3);
  endtask : t_write_read

  task automatic t_deselect;
    op(sdpi_pkg::cmd_read, 2'h1, 12'h003, 2'h0, 16'h0000);
    u_ctrl.drive(sdpi_pkg::cmd_act, 1'b1, 2'h2, 12'h000, 2'h0, 16'h0000, 1'b1);
    u_ctrl.drive(sdpi_pkg::cmd_nop, 1'b1, 2'h0, 12'h000, 2'h0, 16'h0000, 1'b1);
    idle(1);
    chk(oe, 16'hFFFF);
    chk(bopen, 16'h0002);
  endtask : t_deselect

  task automatic t_lowpower;
    u_ctrl.drive(sdpi_pkg::cmd_act, 1'b0, 2'h2, 12'h000, 2'h0, 16'h0000, 1'b0);
    u_ctrl.drive(sdpi_pkg::cmd_nop, 1'b0, 2'h0, 12'h000, 2'h0, 16'h0000, 1'b0);
    #1;
    chk(16'(pstate), 16'(sdpi_pkg::lp_power_down));
    chk(bopen, 16'h0002);
    idle(2);
    chk(16'(pstate), 16'(sdpi_pkg::lp_none));
    u_ctrl.drive(sdpi_pkg::cmd_ref, 1'b0, 2'h0, 12'h000, 2'h0, 16'h0000, 1'b0);
    u_ctrl.drive(sdpi_pkg::cmd_nop, 1'b0, 2'h0, 12'h000, 2'h0, 16'h0000, 1'b0);
    #1;
    chk(16'(pstate), 16'(sdpi_pkg::lp_self_refresh));
    idle(2);
    op(sdpi_pkg::cmd_read, 2'h1, 12'h003, 2'h0, 16'h0000);
    u_ctrl.drive(sdpi_pkg::cmd_nop, 1'b0, 2'h0, 12'h000, 2'h0, 16'h0000, 1'b0);
    u_ctrl.drive(sdpi_pkg::cmd_nop, 1'b0, 2'h0, 12'h000, 2'h0, 16'h0000, 1'b0);
    #1;
    chk(16'(pstate), 16'(sdpi_pkg::lp_suspend));
    idle(5);
  endtask : t_lowpower

  task automatic t_precharge;
    op(sdpi_pkg::cmd_act, 2'h0, 12'h000, 2'h0, 16'h0000);
    op(sdpi_pkg::cmd_act, 2'h2, 12'h000, 2'h0, 16'h0000);
    idle(1);
    chk(bopen, 16'h0007);
    op(sdpi_pkg::cmd_pre, 2'h1, 12'h000, 2'h0, 16'h0000);
    idle(1);
    chk(bopen, 16'h0005);
    op(sdpi_pkg::cmd_pre, 2'h0, 12'h400, 2'h0, 16'h0000);
    idle(1);
    chk(bopen, 16'h0000);
  endtask : t_precharge

  task automatic t_mode;
    op(sdpi_pkg::cmd_bst, 2'h0, 12'h000, 2'h0, 16'h0000);
    op(sdpi_pkg::cmd_ref, 2'h0, 12'h000, 2'h0, 16'h0000);
    op(sdpi_pkg::cmd_lmr, 2'h0, 12'h030, 2'h0, 16'h0000);
    idle(1);
    chk(cerr, 16'h0000);
    op(sdpi_pkg::cmd_act, 2'h3, 12'h000, 2'h0, 16'h0000);
    op(sdpi_pkg::cmd_read, 2'h3, 12'h000, 2'h0, 16'h0000);
    idle(3);
    chk(oe, 16'h0000);
    idle(1);
    chk(oe, 16'hFFFF);
    op(sdpi_pkg::cmd_ref, 2'h0, 12'h000, 2'h0, 16'h0000);
    idle(1);
    chk(cerr, 16'h0001);
  endtask : t_mode

  // Back-to-back writes through the queue, each address written twice, the second time with the upper byte masked
  task automatic t_queue;
    for (int i = 0; i < 16; i++) begin
      op(sdpi_pkg::cmd_write, 2'h3, 12'(i), 2'h0, 16'hA050 + 16'(i) * 16'h0101);
      op(sdpi_pkg::cmd_write, 2'h3, 12'(i), 2'h2, 16'h0000);
      #1;
      chk(wqf, 16'h0000);
    end
    // Last read carries the scope bit, so the bank closes behind it
    for (int i = 0; i < 16; i++) begin
      op(sdpi_pkg::cmd_read, 2'h3, 12'(i) | ((i == 15) ? 12'h400 : 12'h000), 2'h0, 16'h0000);
      idle(4);
      chk(oe, 16'hFFFF);
      chk(dout, 16'hA000 + 16'(i) * 16'h0100);
    end
    chk(bopen, 16'h0000);
  endtask : t_queue

  task automatic close_out;
    if (errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  initial begin
    errors     = 0;
    n_compared = 0;
    rstn       = 1'b0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    #1;
    t_reset();
    t_activate();
    t_write_read();
    t_deselect();
    t_lowpower();
    t_precharge();
    t_mode();
    t_queue();
    close_out();
  end
endmodule : sdram_pin_command_interface_tb_top
